// ==== rtl/fws_pkg.sv ====
package fws_pkg;

  // -------------------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // -------------------------------------------------------------------------
  localparam logic [7:0] FWS_CTRL_OFF = 8'h00;
  localparam logic [7:0] FWS_ADDR_OFF = 8'h04;
  localparam logic [7:0] FWS_WDAT_OFF = 8'h08;
  localparam logic [7:0] FWS_STAT_OFF = 8'h0C;
  localparam logic [7:0] FWS_RDAT_OFF = 8'h10;

  // -------------------------------------------------------------------------
  // control register fields
  // -------------------------------------------------------------------------
  localparam int FWS_CTRL_GO_BIT = 0;
  localparam int FWS_CTRL_KIND_LSB = 1;
  localparam int FWS_CTRL_KIND_MSB = 2;
  localparam int FWS_CTRL_CE_BIT = 3;

  // command kinds
  localparam logic [1:0] FWS_KIND_WRITE = 2'h0;
  localparam logic [1:0] FWS_KIND_READ = 2'h1;
  localparam logic [1:0] FWS_KIND_POLL = 2'h2;
  localparam logic [1:0] FWS_KIND_WINDOW = 2'h3;

  // -------------------------------------------------------------------------
  // status register fields
  // -------------------------------------------------------------------------
  localparam int FWS_ST_BUSY_BIT = 0;
  localparam int FWS_ST_DONE_BIT = 1;
  localparam int FWS_ST_FAIL_BIT = 2;
  localparam int FWS_ST_RYBY_BIT = 3;
  localparam int FWS_ST_WIN_BIT = 4;
  localparam int FWS_ST_RESET_BIT = 5;

  // -------------------------------------------------------------------------
  // flash data bus status bit positions
  // -------------------------------------------------------------------------
  localparam int FWS_DQ_POLL = 7;
  localparam int FWS_DQ_OPTOG = 6;
  localparam int FWS_DQ_TMO = 5;
  localparam int FWS_DQ_WIN = 3;
  localparam int FWS_DQ_SECTOG = 2;

  // reset command word written after a failed operation
  localparam logic [15:0] FWS_RESET_CMD = 16'h00F0;
  localparam logic [31:0] FWS_RESET_VAL = 32'h0000_0000;

  // -------------------------------------------------------------------------
  // bus cycle timing
  // -------------------------------------------------------------------------
  localparam int FWS_T_STROBE_NS = 60;
  localparam int FWS_T_HOLD_NS = 20;
  localparam int FWS_CLK_NS = 4;
  localparam logic [5:0] FWS_STROBE_CYC =
    6'((FWS_T_STROBE_NS + FWS_CLK_NS - 1) / FWS_CLK_NS);
  localparam logic [5:0] FWS_HOLD_CYC =
    6'((FWS_T_HOLD_NS + FWS_CLK_NS - 1) / FWS_CLK_NS);

  typedef enum logic [1:0] {
    FWS_CYC_IDLE,
    FWS_CYC_STROBE,
    FWS_CYC_HOLD
  } fws_cyc_state_t;

  typedef enum logic [2:0] {
    FWS_SEQ_IDLE,
    FWS_SEQ_FIRST,
    FWS_SEQ_SECOND,
    FWS_SEQ_RECHECK,
    FWS_SEQ_RESET,
    FWS_SEQ_DATA,
    FWS_SEQ_SINGLE
  } fws_seq_state_t;

endpackage : fws_pkg

// ==== rtl/fws_apb_regs.sv ====
`timescale 1ns/1ps
module fws_apb_regs
  import fws_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] stat_in,
  input wire logic [15:0] rdat_in,
  input wire logic busy_in,
  output logic go_pulse,
  output logic [1:0] kind,
  output logic use_ce,
  output logic [22:0] addr,
  output logic [15:0] wdat
);

  typedef struct packed {
    logic [3:0] ctrl;
    logic [22:0] addr;
    logic [15:0] wdat;
    logic go;
  } fws_reg_st_t;

  fws_reg_st_t s_q;
  fws_reg_st_t s_d;
  logic wr;
  logic mapped;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == FWS_CTRL_OFF) begin
      prdata = {28'h0000000, s_q.ctrl};
    end else if (paddr == FWS_ADDR_OFF) begin
      prdata = {9'h000, s_q.addr};
    end else if (paddr == FWS_WDAT_OFF) begin
      prdata = {16'h0000, s_q.wdat};
    end else if (paddr == FWS_STAT_OFF) begin
      prdata = stat_in;
    end else if (paddr == FWS_RDAT_OFF) begin
      prdata = {16'h0000, rdat_in};
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = psel && penable && !mapped;

  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;
    // writes while busy are dropped so a running sequence keeps its orders
    if (wr && !busy_in) begin
      if (paddr == FWS_CTRL_OFF) begin
        s_d.ctrl = pwdata[3:0];
        s_d.go = pwdata[FWS_CTRL_GO_BIT];
      end else if (paddr == FWS_ADDR_OFF) begin
        s_d.addr = pwdata[22:0];
      end else if (paddr == FWS_WDAT_OFF) begin
        s_d.wdat = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign go_pulse = s_q.go;
  assign kind = s_q.ctrl[FWS_CTRL_KIND_MSB:FWS_CTRL_KIND_LSB];
  assign use_ce = s_q.ctrl[FWS_CTRL_CE_BIT];
  assign addr = s_q.addr;
  assign wdat = s_q.wdat;

endmodule : fws_apb_regs

// ==== rtl/fws_bus_cycle.sv ====
`timescale 1ns/1ps
module fws_bus_cycle
  import fws_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic use_ce,
  input wire logic [22:0] addr_in,
  input wire logic [15:0] wdat_in,
  output logic done,
  output logic [15:0] rdat,
  output logic [22:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [15:0] data_bus_in,
  output logic [15:0] data_bus_out,
  output logic data_bus_oe
);

  typedef struct packed {
    fws_cyc_state_t st;
    logic [5:0] cnt;
    logic wr;
    logic ce_ctl;
    logic [22:0] addr;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic done;
  } fws_cyc_st_t;

  fws_cyc_st_t s_q;
  fws_cyc_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      FWS_CYC_IDLE: begin
        if (start) begin
          s_d.st = FWS_CYC_STROBE;
          s_d.cnt = FWS_STROBE_CYC;
          s_d.wr = is_write;
          s_d.ce_ctl = use_ce;
          s_d.addr = addr_in;
          s_d.wdat = wdat_in;
        end
      end
      FWS_CYC_STROBE: begin
        if (s_q.cnt == 6'h01) begin
          // sample at end of strobe, before it rises
          s_d.rdat = data_bus_in;
          s_d.st = FWS_CYC_HOLD;
          s_d.cnt = FWS_HOLD_CYC;
        end else begin
          s_d.cnt = s_q.cnt - 6'h01;
        end
      end
      FWS_CYC_HOLD: begin
        if (s_q.cnt == 6'h01) begin
          s_d.st = FWS_CYC_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 6'h01;
        end
      end
      default: s_d.st = FWS_CYC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  logic strobe;
  assign strobe = (s_q.st == FWS_CYC_STROBE);
  // reads: strobe either output enable or chip select, chosen per command
  assign flash_ce_n = s_q.ce_ctl && !s_q.wr ? !strobe
                      : (s_q.st == FWS_CYC_IDLE);
  assign flash_oe_n = s_q.wr ? 1'b1
                      : (s_q.ce_ctl ? (s_q.st == FWS_CYC_IDLE) : !strobe);
  assign flash_we_n = !(s_q.wr && strobe);
  assign flash_addr = s_q.addr;
  assign data_bus_out = s_q.wdat;
  assign data_bus_oe = s_q.wr && (s_q.st != FWS_CYC_IDLE);
  assign done = s_q.done;
  assign rdat = s_q.rdat;

endmodule : fws_bus_cycle

// ==== rtl/fws_host.sv ====
`timescale 1ns/1ps
// Behaviour
// - reads controlled by output or chip select
// - poll starts with two back-to-back reads
// - toggling stopped means done; next read data
// - toggling with timeout set: recheck, then reset
// - continued polling pairs each new read with the previous one
// - after timeout host writes reset command
// - fast follow-on sector erases need no window check
// - check window bit around each extra erase
// - status reads use program or erasing address
// - status reads address the busy bank
module fws_host
  import fws_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [22:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [15:0] data_bus_in,
  output logic [15:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic ready_busy_n_out
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    fws_seq_state_t st;
    logic start;
    logic is_write;
    logic [15:0] first;
    logic [15:0] rdat;
    logic done;
    logic fail;
    logic win;
    logic did_reset;
  } fws_host_st_t;

  fws_host_st_t s_q;
  fws_host_st_t s_d;

  logic go;
  logic [1:0] kind;
  logic use_ce;
  logic [22:0] addr;
  logic [15:0] wdat;
  logic cyc_done;
  logic [15:0] cyc_rdat;
  logic busy;
  logic [31:0] stat;
  logic [15:0] cyc_wdat;
  logic toggled;

  assign busy = (s_q.st != FWS_SEQ_IDLE);

  // -------------------------------------------------------------------------
  // register file
  // -------------------------------------------------------------------------
  fws_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .stat_in(stat),
    .rdat_in(s_q.rdat),
    .busy_in(busy),
    .go_pulse(go),
    .kind(kind),
    .use_ce(use_ce),
    .addr(addr),
    .wdat(wdat)
  );

  always_comb begin
    stat = FWS_RESET_VAL;
    stat[FWS_ST_BUSY_BIT] = busy;
    stat[FWS_ST_DONE_BIT] = s_q.done;
    stat[FWS_ST_FAIL_BIT] = s_q.fail;
    // pin low means the device is programming or erasing
    stat[FWS_ST_RYBY_BIT] = ready_busy_n_out;
    stat[FWS_ST_WIN_BIT] = s_q.win;
    stat[FWS_ST_RESET_BIT] = s_q.did_reset;
  end

  // -------------------------------------------------------------------------
  // one flash bus cycle at a time
  // -------------------------------------------------------------------------
  // status reads always use the programmed or erasing address
  assign cyc_wdat = (s_q.st == FWS_SEQ_RESET) ? FWS_RESET_CMD : wdat;

  fws_bus_cycle u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .start(s_q.start),
    .is_write(s_q.is_write),
    .use_ce(use_ce),
    .addr_in(addr),
    .wdat_in(cyc_wdat),
    .done(cyc_done),
    .rdat(cyc_rdat),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe)
  );

  // only the operation toggle bit is compared; the sector toggle bit is not checked
  assign toggled = (cyc_rdat[FWS_DQ_OPTOG] != s_q.first[FWS_DQ_OPTOG]);

  // -------------------------------------------------------------------------
  // polling sequencer
  // -------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    case (s_q.st)
      FWS_SEQ_IDLE: begin
        if (go) begin
          s_d.done = 1'b0;
          s_d.start = 1'b1;
          s_d.is_write = (kind == FWS_KIND_WRITE);
          if (kind == FWS_KIND_POLL) begin
            // every poll restarts at the first pair
            s_d.fail = 1'b0;
            s_d.did_reset = 1'b0;
            s_d.st = FWS_SEQ_FIRST;
          end else begin
            // window check is optional for fast follow-ons
            s_d.st = FWS_SEQ_SINGLE;
          end
        end
      end
      FWS_SEQ_SINGLE: begin
        if (cyc_done) begin
          s_d.rdat = cyc_rdat;
          if (kind == FWS_KIND_WINDOW) begin
            // one means erase began; extra erase may be lost
            s_d.win = cyc_rdat[FWS_DQ_WIN];
          end
          s_d.done = 1'b1;
          s_d.st = FWS_SEQ_IDLE;
        end
      end
      FWS_SEQ_FIRST: begin
        if (cyc_done) begin
          s_d.first = cyc_rdat;
          s_d.start = 1'b1;
          s_d.is_write = 1'b0;
          s_d.st = FWS_SEQ_SECOND;
        end
      end
      FWS_SEQ_SECOND: begin
        if (cyc_done) begin
          s_d.start = 1'b1;
          s_d.is_write = 1'b0;
          s_d.first = cyc_rdat;
          if (!toggled) begin
            s_d.st = FWS_SEQ_DATA;
          end else if (cyc_rdat[FWS_DQ_TMO]) begin
            // timeout bit may rise as toggling ends; test again
            s_d.st = FWS_SEQ_RECHECK;
          end else begin
            s_d.st = FWS_SEQ_SECOND;
          end
        end
      end
      FWS_SEQ_RECHECK: begin
        if (cyc_done) begin
          s_d.start = 1'b1;
          if (!toggled) begin
            s_d.is_write = 1'b0;
            s_d.st = FWS_SEQ_DATA;
          end else begin
            // stuck: reset returns the device to read mode
            s_d.is_write = 1'b1;
            s_d.fail = 1'b1;
            s_d.st = FWS_SEQ_RESET;
          end
        end
      end
      FWS_SEQ_RESET: begin
        if (cyc_done) begin
          s_d.did_reset = 1'b1;
          s_d.done = 1'b1;
          s_d.st = FWS_SEQ_IDLE;
        end
      end
      FWS_SEQ_DATA: begin
        // read after toggling stopped carries true array data
        if (cyc_done) begin
          s_d.rdat = cyc_rdat;
          s_d.done = 1'b1;
          s_d.st = FWS_SEQ_IDLE;
        end
      end
      default: s_d.st = FWS_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : fws_host

// ==== dv/fws_host_properties.sv ====
`timescale 1ns/1ps
module fws_host_checker
  import fws_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [22:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic data_bus_oe
);
  // ------
  // checks
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_no_wait: assert property (psel && penable |-> pready)
    else $error("apb access stalled");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h10
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_we_len: assert property ($fell(flash_we_n)
    |-> ##14 !flash_we_n ##1 flash_we_n)
    else $error("write strobe not 15 cycles");
  a_wr_hold: assert property ($rose(flash_we_n)
    |-> (flash_we_n && data_bus_oe)[*5])
    else $error("write data not held");
  a_wr_form: assert property (!flash_we_n
    |-> flash_oe_n && !flash_ce_n && data_bus_oe)
    else $error("malformed write strobe");
  a_rd_no_drive: assert property (!flash_oe_n |-> !data_bus_oe)
    else $error("bus driven during read");
  a_oe_len: assert property ($fell(flash_oe_n)
    |-> !flash_oe_n[*8])
    else $error("read strobe too short");
  a_ce_len: assert property ($fell(flash_ce_n)
    |-> !flash_ce_n[*8])
    else $error("select strobe too short");
  a_addr_held: assert property (!flash_ce_n && !$past(flash_ce_n)
    |-> $stable(flash_addr))
    else $error("address moved in cycle");
endmodule : fws_host_checker

bind fws_host fws_host_checker u_fws_host_checker (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
  .data_bus_oe
);

// ==== dv/fws_flash_model.sv ====
`timescale 1ns/1ps
module fws_flash_model (
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [22:0] flash_addr,
  input wire logic [15:0] data_bus_out,
  input wire logic [7:0] run_len,
  output logic [15:0] data_bus_in,
  output logic ready_busy_n_out
);
  // ------------
  // device state
  // ------------
  logic [15:0] mem, pdat, stat, last;
  logic [7:0] left;
  logic [1:0] wcnt;
  logic [4:0] sec;
  logic busy, erase, fail, tmo, tog, tog2, bank, susp;
  wire rd_n = flash_ce_n | flash_oe_n | ~flash_we_n;
  wire in_sec = erase && flash_addr[20:16] == sec;
  // while suspended only the suspended sector reports status
  wire hit = busy && flash_addr[22] == bank && (!susp || in_sec);

  initial begin
    mem = 16'hFFFF;
    last = 16'h0000;
    busy = 1'b0;
    tmo = 1'b0;
    tog = 1'b0;
    tog2 = 1'b0;
    susp = 1'b0;
    erase = 1'b0;
  end

  // address bit 21 stands in for the sector erase command
  // select checked so the strobe settling at reset is no command
  always @(posedge flash_we_n) begin
    if (flash_ce_n === 1'b0) begin
      if (data_bus_out == 16'h00F0) begin
        busy = 1'b0;
        tmo = 1'b0;
        susp = 1'b0;
      end else if (busy && erase && data_bus_out == 16'h00B0) begin
        susp = 1'b1; // while busy only reset, suspend and resume are taken
      end else if (susp && data_bus_out == 16'h0030) begin
        susp = 1'b0;
      end else if (!busy) begin // busy: command ignored
        erase = flash_addr[21];
        sec = flash_addr[20:16];
        bank = flash_addr[22];
        pdat = data_bus_out;
        fail = !erase && |(data_bus_out & ~mem);
        left = run_len;
        wcnt = 2'h2;
        busy = 1'b1;
      end
    end
  end

  always_comb begin
    stat = mem; // idle, other bank or, while suspended, other sector: array data
    if (hit) begin
      stat = 16'h0000;
      stat[7] = susp || !erase && !pdat[7];
      stat[6] = tog;
      stat[5] = tmo;
      stat[3] = erase && wcnt == 2'h0;
      stat[2] = in_sec && tog2;
    end
  end

  // released bus shows the inverse of the last word, never a copy
  assign data_bus_in = rd_n ? ~last : stat;
  // pull-up when released
  assign ready_busy_n_out = !busy || susp;

  always @(posedge rd_n) begin
    last = stat;
    if (hit) begin
      tog2 = !tog2;
      // suspend freezes the operation bit and the run
      if (!susp) begin
        tog = !tog;
        if (wcnt != 2'h0) wcnt = wcnt - 2'h1;
        if (left != 8'h0) left = left - 8'h1;
        else if (fail) tmo = 1'b1;
        else begin
          busy = 1'b0;
          mem = erase ? 16'hFFFF : pdat;
        end
      end
    end
  end
endmodule : fws_flash_model

// ==== dv/fws_host_bench.sv ====
`timescale 1ns/1ps
module fws_host_bench
  import fws_pkg::*;
;
  // -------
  // harness
  // -------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, run_len;
  logic [31:0] pwdata, prdata, q, p;
  logic [22:0] flash_addr;
  logic flash_ce_n, flash_oe_n, flash_we_n, data_bus_oe;
  logic ready_busy_n_out;
  logic [15:0] data_bus_out, dev_q;
  int n_errors, cmp_count;
  wire [15:0] dq = data_bus_oe ? data_bus_out : dev_q;

  fws_host u_fws_host (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .flash_addr, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .data_bus_in(dq), .data_bus_out,
    .data_bus_oe, .ready_busy_n_out
  );
  fws_flash_model u_fws_flash_model (
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
    .data_bus_out(dq), .run_len, .data_bus_in(dev_q),
    .ready_busy_n_out
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // -----
  // tasks
  // -----
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : apb

  // one flash operation, then wait until the sequencer is idle
  task automatic op(input logic [1:0] k, input logic [22:0] a,
                    input logic ce);
    int n;
    apb(1'b1, FWS_ADDR_OFF, {9'h000, a});
    apb(1'b1, FWS_CTRL_OFF, {28'h0000000, ce, k, 1'b1});
    n = 0;
    do begin
      apb(1'b0, FWS_STAT_OFF, 32'h0);
      n++;
    end while (q[FWS_ST_BUSY_BIT] !== 1'b0 && n < 900);
    if (n >= 900) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : op

  task automatic prog(input logic [22:0] a, input logic [15:0] w);
    apb(1'b1, FWS_WDAT_OFF, {16'h0000, w});
    op(FWS_KIND_WRITE, a, 1'b0);
  endtask : prog

  // --------
  // sequence
  // --------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    run_len = 8'h00;
    n_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FWS_STAT_OFF, 32'h0);
    chk(q, 32'h0000_0008);
    apb(1'b0, 8'h20, 32'h0);
    chk({q[30:0], e}, 32'h0000_0001);
    // prompt program, then poll to completion
    prog(23'h000100, 16'h1234);
    apb(1'b0, FWS_STAT_OFF, 32'h0);
    chk(q & 32'h8, 32'h0);
    op(FWS_KIND_POLL, 23'h000100, 1'b0);
    apb(1'b0, FWS_STAT_OFF, 32'h0);
    chk(q & 32'h2F, 32'h0000_000A);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    chk(q, 32'h0000_1234);
    // one over zero fails; polled with select strobing
    run_len <= 8'h04;
    prog(23'h000100, 16'h00FF);
    op(FWS_KIND_POLL, 23'h000100, 1'b1);
    apb(1'b0, FWS_STAT_OFF, 32'h0);
    chk(q & 32'h2F, 32'h0000_002E);
    op(FWS_KIND_READ, 23'h000100, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    chk(q, 32'h0000_1234);
    // slow sector erase of sector 3
    run_len <= 8'h14;
    prog(23'h230000, 16'h0030);
    for (int i = 0; i < 3; i++) begin
      op(FWS_KIND_WINDOW, 23'h230000, 1'b0);
      apb(1'b0, FWS_STAT_OFF, 32'h0);
      chk(q & 32'h10, (i == 2) ? 32'h10 : 32'h0);
    end
    op(FWS_KIND_READ, 23'h430000, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    chk(q, 32'h0000_1234);
    op(FWS_KIND_READ, 23'h230000, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    p = q;
    op(FWS_KIND_READ, 23'h230000, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    chk((q ^ p) & 32'hCC, 32'h44);
    // suspend: ready high, sector bit toggles, operation bit steady
    prog(23'h230000, 16'h00B0);
    apb(1'b0, FWS_STAT_OFF, 32'h0);
    chk(q & 32'h8, 32'h8);
    op(FWS_KIND_READ, 23'h230000, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    p = q;
    op(FWS_KIND_READ, 23'h230000, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    chk(((q ^ p) & 32'h44) | (q & 32'h80), 32'h84);
    op(FWS_KIND_READ, 23'h210000, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    chk(q, 32'h0000_1234);
    prog(23'h230000, 16'h0030);
    op(FWS_KIND_POLL, 23'h230000, 1'b0);
    apb(1'b0, FWS_RDAT_OFF, 32'h0);
    chk(q, 32'h0000_FFFF);
    tally_and_finish();
  end
endmodule : fws_host_bench
